// ==== rtl/vcac_defines.vh ====
// Constants for the cursor, annunciator and configuration register bank.
// Assumes a 125 MHz system clock and a 16-bit serial frame.
`ifndef VCAC_DEFINES_VH
`define VCAC_DEFINES_VH

// Command addresses, 7 bits
`define VCAC_CURSOR_ADDR 7'h0f
`define VCAC_CONFIG_ADDR 7'h0c
`define VCAC_DATA_LO 7'h20
`define VCAC_DATA_HI 7'h7f
`define VCAC_DATA_WORDS 96

// Serial frame layout
`define VCAC_FRAME_BITS 16
`define VCAC_HDR_BITS 8
`define VCAC_RW_POS 15
`define VCAC_ADDR_MSB 14
`define VCAC_ADDR_LSB 8

// Configuration field positions
`define VCAC_CFG_S 0
`define VCAC_CFG_L 1
`define VCAC_CFG_B 2
`define VCAC_CFG_X 3
`define VCAC_CFG_T 4
`define VCAC_CFG_R 5
`define VCAC_CFG_M 6
`define VCAC_CFG_P 7

// Cursor field positions
`define VCAC_CUR_BLINK 7
`define VCAC_CUR_NONE_HI 6
`define VCAC_CUR_NONE_LO 5

// Annunciator field codes
`define VCAC_ANN_OFF 2'b00
`define VCAC_ANN_FIRST 2'b01
`define VCAC_ANN_SECOND 2'b10
`define VCAC_ANN_ON 2'b11

// Reset values
`define VCAC_CFG_RST 8'h00
`define VCAC_CUR_RST 8'h60
`define VCAC_DATA_RST 8'h00

// Blink half periods in milliseconds and the clock rate in kHz
`define VCAC_SLOW_HALF_MS 1000
`define VCAC_FAST_HALF_MS 500
`define VCAC_CLK_KHZ 125000
`define VCAC_SLOW_HALF_CYC (`VCAC_SLOW_HALF_MS * `VCAC_CLK_KHZ)
`define VCAC_FAST_HALF_CYC (`VCAC_FAST_HALF_MS * `VCAC_CLK_KHZ)
`define VCAC_BLINK_CNT_W 27

`endif

// ==== rtl/vcac_regs.v ====
// Cursor, annunciator data and configuration registers of the display
// controller, written and read over the serial slave front end.
// Assumes the scan engine samples the lit outputs it selects.
//
// Behaviour
// - The cursor register at command address 0x0F holds a blink bit in D7 and a position in D6:D0.
// - A blinking cursor lights only in the first half of the blink period, otherwise it is lit.
// - Position 0 is digit 1 up to 1011111 for digit 96, and positions with D6 and D5 set show none.
// - An annunciator byte holds four two-bit fields, first in D1:D0 up to fourth in D7:D6.
// - A field decodes 00 off, 01 first half, 10 second half and 11 continuously lit.
// - Configuration D0 gives shutdown at 0 and normal operation at 1.
// - Configuration D1 shows unlocked at 0 and locked at 1.
// - Configuration D2 at 0 gives slow blinking with 1 s on and 1 s off.
// - Configuration D2 at 1 gives fast blinking with 0.5 s on and 0.5 s off.
// - With configuration D4 set the blink counters clear on the chip select rising edge.
// - With configuration D5 set data at 0x20 to 0x7F clears on the chip select rising edge.
// - Configuration D6 picks 48 digits one per grid at 0 or 96 digits two per grid at 1.
// - Reading configuration returns the blink phase in D7, 0 first phase and 1 second.
// - A transfer is 16 bits, R/W in D15, address in D14:D8, data in D7:D0, MSB first.
`timescale 1ns/1ps
`include "vcac_defines.vh"

module vcac_regs #(
	parameter SLOW_HALF_CYC = `VCAC_SLOW_HALF_CYC,
	parameter FAST_HALF_CYC = `VCAC_FAST_HALF_CYC
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire cs_n,
	input wire sclk,
	input wire din,
	input wire [6:0] ann_addr,
	output wire dout,
	output reg cursor_lit,
	output reg [6:0] cursor_digit,
	output reg [3:0] ann_lit,
	output reg display_on,
	output reg config_locked,
	output reg blink_fast,
	output reg two_digit_mode,
	output reg blink_phase
);

	// Last count of each half period, cut to the counter width on purpose
	localparam integer SLOW_LAST_I = SLOW_HALF_CYC - 1;
	localparam integer FAST_LAST_I = FAST_HALF_CYC - 1;
	localparam [`VCAC_BLINK_CNT_W-1:0] SLOW_LAST = SLOW_LAST_I[`VCAC_BLINK_CNT_W-1:0];
	localparam [`VCAC_BLINK_CNT_W-1:0] FAST_LAST = FAST_LAST_I[`VCAC_BLINK_CNT_W-1:0];

	reg [7:0] cursor_control;
	reg [7:0] device_configuration;
	reg [7:0] data_mem [0:`VCAC_DATA_WORDS-1];
	reg [`VCAC_BLINK_CNT_W-1:0] blink_cnt;
	reg [7:0] rd_byte;
	reg [7:0] ann_byte;
	wire [15:0] rx_word;
	wire hdr_valid;
	wire word_valid;
	wire cs_rise;
	wire [6:0] wr_addr;
	wire [7:0] wr_data;
	wire wr_en;
	wire [`VCAC_BLINK_CNT_W-1:0] half_last;
	wire blink_tick;
	integer i;

	////////////////////////////////////////////////////////////////////
	// Helper functions

	// True for addresses in the segment and annunciator data range
	function in_data;
		input [6:0] addr;
		begin
			in_data = (addr >= `VCAC_DATA_LO) && (addr <= `VCAC_DATA_HI);
		end
	endfunction

	// Memory index of a data address
	function [6:0] data_idx;
		input [6:0] addr;
		begin
			data_idx = addr - `VCAC_DATA_LO;
		end
	endfunction

	function ann_on;
		input [1:0] code;
		input phase;
		begin
			case (code)
				`VCAC_ANN_OFF: ann_on = 1'b0;
				`VCAC_ANN_FIRST: ann_on = ~phase;
				`VCAC_ANN_SECOND: ann_on = phase;
				`VCAC_ANN_ON: ann_on = 1'b1;
				default: ann_on = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Serial front end
	vcac_spi_rx u_rx (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.cs_n_pin(cs_n),
		.sclk_pin(sclk),
		.din_pin(din),
		.rd_byte(rd_byte),
		.rx_word(rx_word),
		.hdr_valid(hdr_valid),
		.word_valid(word_valid),
		.cs_rise(cs_rise),
		.dout(dout)
	);

	assign wr_addr = rx_word[`VCAC_ADDR_MSB:`VCAC_ADDR_LSB];
	assign wr_data = rx_word[7:0];
	assign wr_en = word_valid & ~rx_word[`VCAC_RW_POS];

	////////////////////////////////////////////////////////////////////
	// Read data selection, address taken from the header bits
	always @* begin
		rd_byte = 8'h00;
		if (rx_word[6:0] == `VCAC_CURSOR_ADDR) begin
			rd_byte = cursor_control;
		end else if (rx_word[6:0] == `VCAC_CONFIG_ADDR) begin
			rd_byte = device_configuration;
			rd_byte[`VCAC_CFG_P] = blink_phase;
		end else if (in_data(rx_word[6:0])) begin
			rd_byte = data_mem[data_idx(rx_word[6:0])];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Cursor and configuration registers
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cursor_control <= `VCAC_CUR_RST;
			device_configuration <= `VCAC_CFG_RST;
		end else if (wr_en) begin
			if (wr_addr == `VCAC_CURSOR_ADDR) begin
				cursor_control <= wr_data;
			end
			if (wr_addr == `VCAC_CONFIG_ADDR) begin
				device_configuration <= wr_data;
				device_configuration[`VCAC_CFG_X] <= 1'b0;
				device_configuration[`VCAC_CFG_P] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Segment and annunciator data memory
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < `VCAC_DATA_WORDS; i = i + 1) begin
				data_mem[i] <= `VCAC_DATA_RST;
			end
		end else if (cs_rise && device_configuration[`VCAC_CFG_R]) begin
			for (i = 0; i < `VCAC_DATA_WORDS; i = i + 1) begin
				data_mem[i] <= `VCAC_DATA_RST;
			end
		end else if (wr_en && in_data(wr_addr)) begin
			data_mem[data_idx(wr_addr)] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////
	// half period by rate
	assign half_last = device_configuration[`VCAC_CFG_B] ? FAST_LAST : SLOW_LAST;
	assign blink_tick = (blink_cnt >= half_last);

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			blink_cnt <= {`VCAC_BLINK_CNT_W{1'b0}};
			blink_phase <= 1'b0;
		end else if (cs_rise && device_configuration[`VCAC_CFG_T]) begin
			blink_cnt <= {`VCAC_BLINK_CNT_W{1'b0}};
			blink_phase <= 1'b0;
		end else if (blink_tick) begin
			blink_cnt <= {`VCAC_BLINK_CNT_W{1'b0}};
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Annunciator byte lookup for the scan address
	always @* begin
		ann_byte = 8'h00;
		if (in_data(ann_addr)) begin
			ann_byte = data_mem[data_idx(ann_addr)];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registered display outputs
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cursor_lit <= 1'b0;
			cursor_digit <= 7'h00;
			ann_lit <= 4'h0;
			display_on <= 1'b0;
			config_locked <= 1'b0;
			blink_fast <= 1'b0;
			two_digit_mode <= 1'b0;
		end else begin
			cursor_digit <= cursor_control[6:0];
			cursor_lit <= ~(cursor_control[`VCAC_CUR_NONE_HI] &
				cursor_control[`VCAC_CUR_NONE_LO]) &
				(~cursor_control[`VCAC_CUR_BLINK] | ~blink_phase);
			ann_lit[0] <= ann_on(ann_byte[1:0], blink_phase);
			ann_lit[1] <= ann_on(ann_byte[3:2], blink_phase);
			ann_lit[2] <= ann_on(ann_byte[5:4], blink_phase);
			ann_lit[3] <= ann_on(ann_byte[7:6], blink_phase);
			display_on <= device_configuration[`VCAC_CFG_S];
			config_locked <= device_configuration[`VCAC_CFG_L];
			blink_fast <= device_configuration[`VCAC_CFG_B];
			two_digit_mode <= device_configuration[`VCAC_CFG_M];
		end
	end

endmodule

// ==== rtl/vcac_spi_rx.v ====
// Serial slave front end: synchronises chip select, serial clock and data,
// assembles 16-bit frames and shifts read data out on falling clock edges.
// Assumes serial clock idles low and is far slower than clk_sys.
`timescale 1ns/1ps
`include "vcac_defines.vh"

module vcac_spi_rx (
	input wire clk_sys,
	input wire sys_rst,
	input wire cs_n_pin,
	input wire sclk_pin,
	input wire din_pin,
	input wire [7:0] rd_byte,
	output reg [15:0] rx_word,
	output reg hdr_valid,
	output reg word_valid,
	output reg cs_rise,
	output reg dout
);

	reg [2:0] cs_sync;
	reg [2:0] ck_sync;
	reg [1:0] dn_sync;
	reg [4:0] bit_cnt;
	reg [6:0] out_sh;
	wire ck_rise;
	wire ck_fall;
	wire cs_low;

	////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers, plus one edge-detect stage on select and clock
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cs_sync <= 3'h7;
			ck_sync <= 3'h0;
			dn_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[1:0], cs_n_pin};
			ck_sync <= {ck_sync[1:0], sclk_pin};
			dn_sync <= {dn_sync[0], din_pin};
		end
	end

	assign ck_rise = ck_sync[1] & ~ck_sync[2];
	assign ck_fall = ~ck_sync[1] & ck_sync[2];
	assign cs_low = ~cs_sync[1];

	////////////////////////////////////////////////////////////////////
	// frame shift, MSB first
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_word <= 16'h0000;
			bit_cnt <= 5'h00;
			hdr_valid <= 1'b0;
			word_valid <= 1'b0;
			cs_rise <= 1'b0;
		end else begin
			hdr_valid <= 1'b0;
			word_valid <= 1'b0;
			cs_rise <= cs_sync[1] & ~cs_sync[2];
			if (!cs_low) begin
				bit_cnt <= 5'h00;
			end else if (ck_rise && bit_cnt < `VCAC_FRAME_BITS) begin
				rx_word <= {rx_word[14:0], dn_sync[1]};
				bit_cnt <= bit_cnt + 5'h01;
				hdr_valid <= (bit_cnt == `VCAC_HDR_BITS - 1);
				word_valid <= (bit_cnt == `VCAC_FRAME_BITS - 1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data out: load after header, shift on falling edges
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dout <= 1'b0;
			out_sh <= 7'h00;
		end else if (!cs_low) begin
			dout <= 1'b0;
			out_sh <= 7'h00;
		end else if (hdr_valid) begin
			dout <= rx_word[7] & rd_byte[7]; // R/W high means read
			out_sh <= rx_word[7] ? rd_byte[6:0] : 7'h00;
		end else if (ck_fall && bit_cnt > `VCAC_HDR_BITS) begin
			dout <= out_sh[6];
			out_sh <= {out_sh[5:0], 1'b0};
		end
	end

endmodule

// ==== tb/tb_vcac_regs.sv ====
// Self-checking bench for the register bank through the host model.
// Assumes short blink halves so phases can be timed.
`timescale 1ns/1ps
module tb_vcac_regs;
	localparam int SLOW = 400;
	localparam int FAST = 200;
	logic clk_sys, sys_rst, cursor_lit, display_on, config_locked;
	logic blink_fast, two_digit_mode, blink_phase;
	logic [6:0] ann_addr, cursor_digit, a;
	logic [3:0] ann_lit, pins;
	logic [7:0] rd, v, b;
	logic [7:0] cv [3] = '{8'h5f, 8'hdf, 8'he0};
	logic [7:0] av [3] = '{8'he4, 8'h1b, 8'hff};
	logic [31:0] seed;
	wire cs_n, sclk, din, dout;
	int num_errors, cmp_count, cyc, n;
	assign pins = {two_digit_mode, blink_fast, config_locked, display_on};
	vcac_regs #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) u_dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .din(din), .ann_addr(ann_addr),
		.dout(dout), .cursor_lit(cursor_lit), .cursor_digit(cursor_digit),
		.ann_lit(ann_lit), .display_on(display_on), .config_locked(config_locked),
		.blink_fast(blink_fast), .two_digit_mode(two_digit_mode),
		.blink_phase(blink_phase));
	vcac_spi_host u_host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Lamp pattern of one data byte in a phase
	function automatic logic [3:0] ann_exp(input logic [7:0] d, input logic ph);
		for (int k = 0; k < 4; k++)
			ann_exp[k] = d[2 * k +: 2] == 2'b11 || d[2 * k +: 2] == {ph, ~ph};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic acc(input logic [15:0] w, input int hp);
		@(negedge clk_sys);
		u_host.xfer(w, hp, rd);
	endtask
	// Write configuration, check its pins and read-back
	task automatic cfg(input logic [7:0] c);
		acc({8'h0c, c}, 32);
		chk(8'(pins), 8'({c[6], c[2], c[1], c[0]}));
		acc({8'h8c, 8'h00}, 32);
		chk(rd & 8'h7f, c & 8'h77);
	endtask
	// Lamps in both blink phases
	task automatic lamps();
		repeat (2) begin
			@(blink_phase);
			repeat (3) @(negedge clk_sys);
			chk(8'((v[6:5] != 2'b11) && !(v[7] && blink_phase)), 8'(cursor_lit));
			chk(8'(ann_exp(b, blink_phase)), 8'(ann_lit));
		end
	endtask
	// One blink half in cycles
	task automatic per(input int h);
		@(blink_phase);
		@(negedge clk_sys);
		n = 1;
		b = 8'(blink_phase);
		while (8'(blink_phase) === b) begin
			@(negedge clk_sys);
			n++;
		end
		chk(8'(n > h - 3 && n < h + 3), 8'h01);
	endtask
	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		seed = 32'h0000000a;
		sys_rst = 1'b1;
		ann_addr = 7'h00;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys) sys_rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(8'(cursor_digit), 8'h60);
		chk(8'(pins), 8'h00);
		$display("reset test done");
		for (int i = 0; i < 8; i++)
			cfg(i == 0 ? 8'hff : 8'(rnd()));
		cfg(8'h01);
		per(SLOW);
		cfg(8'h05);
		per(FAST);
		$display("config test done");
		for (int i = 0; i < 6; i++) begin
			v = i < 3 ? cv[i] : 8'(rnd());
			b = i < 3 ? av[i] : 8'(rnd());
			a = 7'(7'h20 + rnd() % 96);
			acc({8'h0f, v}, 32);
			acc({1'b0, a, b}, 32);
			@(negedge clk_sys) ann_addr = a;
			acc({8'h8f, 8'h00}, 32);
			chk(rd, v);
			chk(8'(cursor_digit), 8'(v[6:0]));
			acc({1'b1, a, 8'h00}, 32);
			chk(rd, b);
			lamps();
		end
		$display("lamp test done");
		cfg(8'h25);
		acc({1'b1, a, 8'h00}, 32);
		chk(rd, 8'h00);
		chk(8'(ann_lit), 8'h00);
		cfg(8'h15);
		acc({8'h8c, 8'h00}, 32);
		chk(rd, 8'h15);
		repeat (250) @(negedge clk_sys);
		acc({8'h8c, 8'h00}, 32);
		chk(rd, 8'h95);
		acc({8'h90, 8'h00}, 32);
		chk(rd, 8'h00);
		$display("clear test done");
		give_verdict();
	end
endmodule
bind vcac_regs vcac_regs_sva #(.SLOW_HALF_CYC(SLOW_HALF_CYC),
	.FAST_HALF_CYC(FAST_HALF_CYC)) u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.cs_n(cs_n), .ann_addr(ann_addr), .dout(dout), .cursor_lit(cursor_lit),
	.cursor_digit(cursor_digit), .ann_lit(ann_lit), .display_on(display_on),
	.config_locked(config_locked), .blink_fast(blink_fast),
	.two_digit_mode(two_digit_mode), .blink_phase(blink_phase));

// ==== tb/vcac_regs_sva.sv ====
// Port checker for the cursor, annunciator and configuration bank.
// Assumes a bind onto vcac_regs with matching blink parameters.
`timescale 1ns/1ps
module vcac_regs_sva #(
	parameter SLOW_HALF_CYC = 40,
	parameter FAST_HALF_CYC = 20
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire cs_n,
	input wire [6:0] ann_addr,
	input wire dout,
	input wire cursor_lit,
	input wire [6:0] cursor_digit,
	input wire [3:0] ann_lit,
	input wire display_on,
	input wire config_locked,
	input wire blink_fast,
	input wire two_digit_mode,
	input wire blink_phase
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	int cnt;
	int quiet;
	logic ph_q;
	logic cs_q;
	// Cycles since a phase flip or select release, and since select low
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 0;
			quiet <= 0;
			ph_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			cnt <= (blink_phase != ph_q || (cs_n && !cs_q)) ? 0 : cnt + 1;
			quiet <= cs_n ? quiet + 1 : 0;
			ph_q <= blink_phase;
			cs_q <= cs_n;
		end
	end
	sequence cs_idle;
		cs_n [*4];
	endsequence
	sequence phase_near;
		##[1:2] $changed(blink_phase);
	endsequence
	////////////////////////////////////////////////////////////////
	a_slow_bound: assert property (cnt <= SLOW_HALF_CYC + 6)
		else $error("blink half too long");
	a_fast_bound: assert property ((blink_fast && $past(blink_fast) && $past(blink_fast, 2))
		|-> cnt <= FAST_HALF_CYC + 8)
		else $error("fast blink half too long");
	a_dout_idle: assert property (cs_idle |-> !dout)
		else $error("dout not low while deselected");
	a_ann_range: assert property (ann_addr < 7'h20 |=> ann_lit == 4'h0)
		else $error("lamps lit for address outside data range");
	a_cursor_none: assert property ((cursor_digit[6:5] == 2'b11
		&& $past(cursor_digit[6:5]) == 2'b11) |-> !cursor_lit) else $error("cursor lit");
	a_cfg_frame: assert property ($changed({two_digit_mode, blink_fast,
		config_locked, display_on}) |-> quiet < 8) else $error("config moved off frame");
	a_ann_shared: assert property (($changed(ann_lit)
		&& $past(ann_addr) == $past(ann_addr, 2)) |-> (quiet < 8 || cnt < 3) or phase_near)
		else $error("lamp moved without phase change");
	a_cursor_shared: assert property (($changed(cursor_lit)
		&& $stable(cursor_digit)) |-> (quiet < 8 || cnt < 3) or phase_near)
		else $error("cursor moved without phase change");
endmodule

// ==== tb/vcac_spi_host.sv ====
// Serial host model sending 16-bit frames to the register bank.
// Assumes the caller spaces frames; clock parks low between them.
`timescale 1ns/1ps
module vcac_spi_host (
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire dout
);
	// Idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	task automatic xfer(input logic [15:0] w, input int hp, output logic [7:0] rd);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			din = w[i];
			#hp sclk = 1'b1;
			if (i < 8) rd[i] = dout;
			#hp sclk = 1'b0;
		end
		#hp cs_n = 1'b1;
		din = ~din;
		#(hp * 2);
	endtask
endmodule
